// ===== sim/cps_core_model.sv
`timescale 1ns/1ps
module cps_core_model
	import cps_pkg::*;
(
	// Clock
	input  wire logic      clk,
	// Clock gates from the controller
	input  wire cps_gate_s gate,
	// Core requests
	output logic           sleep_instr,
	output cps_wake_s      wake
);
	initial begin
		sleep_instr = 1'b0;
		wake = '0;
	end
	// Source drops once the core clock runs; level held till then
	always @(posedge clk) begin
		if (gate.cpu && |wake)
			wake <= '0;
	end
	// Comparator power-down is software's choice, not modelled
	// One-cycle sleep, never during a divider change
	task automatic do_sleep();
		@(posedge clk) sleep_instr <= 1'b1;
		@(posedge clk) sleep_instr <= 1'b0;
	endtask
	task automatic wake_on(input cps_wake_s src);
		@(posedge clk) wake <= src;
	endtask
endmodule

// ===== sim/cps_top_tb_top.sv
`timescale 1ns/1ps
module cps_top_tb_top;
	import cps_pkg::*;
	logic        clk = 0, nrst = 0, rd = 0, wr = 0, fuse = 0, adc = 1;
	logic [3:0]  addr = '0;
	logic [31:0] wd = '0, rdata, q;
	logic        wreq, sleep, tick, resume, adcs;
	cps_wake_s   wake;
	cps_gate_s   gate;
	int          mismatches = 0, total_checks = 0, ticks = 0, starts = 0;
	// Undivided clock, 100 MHz
	always #5 clk = ~clk;
	always @(posedge clk) begin
		ticks += (tick === 1'b1);
		starts += (adcs === 1'b1);
	end
	cps_top cps_top_i (.SYS_CLK(clk), .NRST(nrst), .CLK_EN(1'b1),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .DIV8_FUSE(fuse), .SLEEP_INSTR(sleep),
		.ADC_ENABLED(adc), .WAKE_SRC(wake), .GATE_EN(gate),
		.SYS_TICK(tick), .CORE_RESUME(resume), .ADC_START(adcs));
	cps_core_model cps_core_model_i (.clk(clk), .gate(gate),
		.sleep_instr(sleep), .wake(wake));
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50)
			chk(0, 1);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic do_reset(input logic f);
		@(posedge clk);
		nrst <= 1'b0;
		fuse <= f;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset();
		do_reset(1);
		bus(0, CPS_OFS_DIV, 0); chk(q, 3);
		do_reset(0);
		bus(0, CPS_OFS_DIV, 0); chk(q, 0);
		bus(0, CPS_OFS_PWR, 0); chk(q, 0);
		bus(0, 4'hc, 0); chk(q, 0);
	endtask
	// Unlock refused, unlock accepted, reserved bits and codes
	task automatic t_unlock();
		bus(1, CPS_OFS_DIV, 8'h81);
		bus(1, CPS_OFS_DIV, 8'h02);
		bus(0, CPS_OFS_DIV, 0); chk(q, 0);
		bus(1, CPS_OFS_DIV, 8'h80);
		bus(0, CPS_OFS_DIV, 0); chk(q, 32'h80);
		bus(1, CPS_OFS_DIV, 8'h80);
		bus(1, CPS_OFS_DIV, 8'h7f);
		bus(0, CPS_OFS_DIV, 0); chk(q, 32'h0f);
		bus(1, CPS_OFS_DIV, 8'h80);
		bus(1, CPS_OFS_DIV, 8'h02);
		bus(0, CPS_OFS_DIV, 0); chk(q, 32'h02);
	endtask
	// Divide by four, then a late code write after the timeout
	task automatic t_tick();
		int t0;
		// Slowest factor must reach its tick before divide by four
		repeat (300) @(posedge clk);
		t0 = ticks;
		repeat (64) @(posedge clk);
		chk(ticks - t0, 16);
		bus(1, CPS_OFS_DIV, 8'h80);
		repeat (40) @(posedge clk);
		bus(0, CPS_OFS_DIV, 0); chk(q, 32'h02);
		bus(1, CPS_OFS_DIV, 8'h00);
		bus(0, CPS_OFS_DIV, 0); chk(q, 32'h02);
	endtask
	// Each mode: gates, ADC start, wake latency, gates back
	task automatic t_sleep(input logic [1:0] m, input logic [5:0] g,
		input int st, input int ad);
		int n, a0;
		a0 = starts;
		bus(1, CPS_OFS_PWR, {2'b0, 1'b1, m, 3'b0});
		cps_core_model_i.do_sleep();
		repeat (3) @(posedge clk);
		chk(gate, g);
		chk(starts - a0, ad);
		if (m == 2'b10) begin
			cps_core_model_i.wake_on(8'h01);
			repeat (10) @(posedge clk);
			chk(gate, g);
		end
		cps_core_model_i.wake_on(8'h20);
		n = 0;
		while (resume !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		chk(n >= st + 4 && n <= st + 8, 1);
		repeat (2) @(posedge clk);
		chk(gate, 6'h3f);
	endtask
	task automatic t_misc();
		bus(1, CPS_OFS_PWR, 8'h00);
		cps_core_model_i.do_sleep();
		repeat (3) @(posedge clk);
		chk(gate, 6'h3f);
		bus(1, CPS_OFS_PWR, 8'h30);
		cps_core_model_i.do_sleep();
		do_reset(0);
		chk(gate, 6'h3f);
	endtask
	initial begin
		#300000;
		mismatches++;
		stop_test();
	end
	initial begin
		t_reset();
		t_unlock();
		t_tick();
		t_sleep(2'b00, 6'b001111, 1, 1);
		t_sleep(2'b01, 6'b000101, 1, 1);
		t_sleep(2'b10, 6'b000000, 8, 0);
		t_sleep(2'b11, 6'b000001, 6, 0);
		t_misc();
		stop_test();
	end
endmodule

// ===== verilog/cps_pkg.sv
package cps_pkg;
	localparam logic [3:0] CPS_OFS_DIV = 4'h0;
	localparam logic [3:0] CPS_OFS_PWR = 4'h4;
	localparam logic [3:0] CPS_OFS_STAT = 4'h8;
	localparam int CPS_UNLOCK_BIT = 7;
	localparam int CPS_SE_BIT = 5;
	localparam int CPS_SM_HI = 4;
	localparam int CPS_SM_LO = 3;
	localparam logic [3:0] CPS_SEL_RST_PLAIN = 4'h0;
	localparam logic [3:0] CPS_SEL_RST_DIV8 = 4'h3;
	localparam logic [3:0] CPS_SEL_MAX = 4'h8;
	localparam logic [2:0] CPS_UNLOCK_CYC = 3'h4;
	localparam logic [3:0] CPS_WAKE_HALT = 4'h4;
	localparam logic [3:0] CPS_STBY_START = 4'h6;
	localparam logic [3:0] CPS_PD_START = 4'h8;

	typedef enum logic [1:0] {
		CPS_SM_IDLE  = 2'b00,
		CPS_SM_NOISE = 2'b01,
		CPS_SM_PDOWN = 2'b10,
		CPS_SM_STBY  = 2'b11
	} cps_mode_e;

	typedef enum logic [1:0] {
		CPS_ST_RUN   = 2'b00,
		CPS_ST_SLEEP = 2'b01,
		CPS_ST_START = 2'b10,
		CPS_ST_HALT  = 2'b11
	} cps_state_e;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic pll;
		logic osc;
	} cps_gate_s;

	typedef struct packed {
		logic ext_a_level;
		logic ext_b_level;
		logic pin_change;
		logic watchdog;
		logic serial;
		logic adc_done;
		logic nvm_ready;
		logic other_io;
	} cps_wake_s;
endpackage

// ===== verilog/cps_top.sv
`timescale 1ns/1ps
module cps_top
	import cps_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        SYS_CLK,
	input  wire logic        NRST,
	input  wire logic        CLK_EN,
	// Avalon-MM slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// Fuse and core
	input  wire logic        DIV8_FUSE,
	input  wire logic        SLEEP_INSTR,
	input  wire logic        ADC_ENABLED,
	input  wire cps_wake_s   WAKE_SRC,
	// Clock gates and events
	output cps_gate_s        GATE_EN,
	output logic             SYS_TICK,
	output logic             CORE_RESUME,
	output logic             ADC_START
);
	// Registers
	logic       unlock_q, unlock_d;
	logic [2:0] ucnt_q, ucnt_d;
	logic [3:0] sel_q, sel_d;
	logic [3:0] act_q, act_d;
	logic [7:0] pre_q, pre_d;
	logic       se_q, se_d;
	logic [1:0] sm_q, sm_d;
	cps_state_e st_q, st_d;
	logic [3:0] wcnt_q, wcnt_d;
	logic       fuse_done_q, fuse_done_d;
	logic [31:0] rdata_q, rdata_d;
	logic       ack_q, ack_d;
	cps_gate_s  gate_q, gate_d;
	logic       tick_q, tick_d;
	logic       resume_q, resume_d;
	logic       adcst_q, adcst_d;

	logic       req, wr_div, wr_pwr, deep_wake, idle_wake, wake;
	logic [3:0] eff_sel;
	logic [7:0] mask;
	cps_mode_e  mode;

	// Bus answers one cycle after the request is seen
	assign req             = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign AVS_READDATA    = rdata_q;
	assign wr_div = AVS_WRITE & ack_q & (AVS_ADDRESS == CPS_OFS_DIV);
	assign wr_pwr = AVS_WRITE & ack_q & (AVS_ADDRESS == CPS_OFS_PWR);
	assign GATE_EN     = gate_q;
	assign SYS_TICK    = tick_q;
	assign CORE_RESUME = resume_q;
	assign ADC_START   = adcst_q;
	assign mode = cps_mode_e'(sm_q);

	// Reserved codes fall back to the slowest defined factor
	assign eff_sel = (sel_q > CPS_SEL_MAX) ? CPS_SEL_MAX : sel_q;
	// Mask of prescaler bits that must be ones for a tick
	assign mask = 8'(({8'h0, 8'h1} << act_q) - 16'h1);

	// Wake qualifiers per mode; deep modes need level external irqs
	assign deep_wake = WAKE_SRC.ext_a_level | WAKE_SRC.ext_b_level
		| WAKE_SRC.pin_change | WAKE_SRC.watchdog
		| WAKE_SRC.serial;
	assign idle_wake = deep_wake | WAKE_SRC.adc_done
		| WAKE_SRC.nvm_ready;
	always_comb begin
		case (mode)
		CPS_SM_IDLE:  wake = idle_wake | WAKE_SRC.other_io;
		CPS_SM_NOISE: wake = idle_wake;
		default:      wake = deep_wake;
		endcase
	end

	// Next state of all control logic
	always_comb begin
		unlock_d    = unlock_q;
		ucnt_d      = ucnt_q;
		sel_d       = sel_q;
		act_d       = act_q;
		pre_d       = pre_q + 8'h1;
		se_d        = se_q;
		sm_d        = sm_q;
		st_d        = st_q;
		wcnt_d      = wcnt_q;
		fuse_done_d = 1'b1;
		ack_d       = req;
		rdata_d     = rdata_q;
		tick_d      = 1'b0;
		resume_d    = 1'b0;
		adcst_d     = 1'b0;
		// Strap sampled once after reset release
		if (!fuse_done_q) begin
			sel_d = DIV8_FUSE ? CPS_SEL_RST_DIV8 : CPS_SEL_RST_PLAIN;
			act_d = sel_d;
		end
		// Tick when low prescaler bits all ones: no glitch steps
		if ((pre_q & mask) == mask) begin
			tick_d = 1'b1;
			// New factor only taken on a tick boundary
			act_d = eff_sel;
			pre_d = 8'h0;
			// Timeout counted in divided cycles
			if (unlock_q) begin
				ucnt_d = ucnt_q + 3'h1;
				if (ucnt_q == CPS_UNLOCK_CYC - 3'h1)
					unlock_d = 1'b0;
			end
		end
		if (wr_div) begin
			if (AVS_WRITEDATA[7:0] == 8'h80) begin
				// Repeat write keeps running window
				if (!unlock_q) begin
					unlock_d = 1'b1;
					ucnt_d   = 3'h0;
				end
			end else if (!AVS_WRITEDATA[CPS_UNLOCK_BIT]) begin
				if (unlock_q)
					sel_d = AVS_WRITEDATA[3:0];
				unlock_d = 1'b0;
			end
		end
		if (wr_pwr) begin
			se_d = AVS_WRITEDATA[CPS_SE_BIT];
			sm_d = AVS_WRITEDATA[CPS_SM_HI:CPS_SM_LO];
		end
		if (req && AVS_READ) begin
			case (AVS_ADDRESS)
			CPS_OFS_DIV:  rdata_d = {24'h0, unlock_q, 3'h0, sel_q};
			CPS_OFS_PWR:  rdata_d = {26'h0, se_q, sm_q, 3'h0};
			CPS_OFS_STAT: rdata_d = {26'h0, st_q, act_q};
			default:      rdata_d = 32'h0;
			endcase
		end
		// Sleep sequencer
		case (st_q)
		CPS_ST_RUN: begin
			if (SLEEP_INSTR && se_q) begin
				st_d = CPS_ST_SLEEP;
				adcst_d = ADC_ENABLED &&
					(mode == CPS_SM_IDLE || mode == CPS_SM_NOISE);
			end
		end
		CPS_ST_SLEEP: begin
			if (wake) begin
				st_d = CPS_ST_START;
				wcnt_d = (mode == CPS_SM_PDOWN) ? CPS_PD_START
					: (mode == CPS_SM_STBY) ? CPS_STBY_START
					: 4'h1;
			end
		end
		CPS_ST_START: begin
			wcnt_d = wcnt_q - 4'h1;
			if (wcnt_q == 4'h1) begin
				st_d = CPS_ST_HALT;
				wcnt_d = CPS_WAKE_HALT;
			end
		end
		CPS_ST_HALT: begin
			wcnt_d = wcnt_q - 4'h1;
			if (wcnt_q == 4'h1) begin
				st_d = CPS_ST_RUN;
				resume_d = 1'b1;
			end
		end
		default: st_d = CPS_ST_RUN;
		endcase
		// Gates follow state; core stays off until halt ends
		gate_d = '{cpu: 1'b1, flash: 1'b1, io: 1'b1,
			adc: 1'b1, pll: 1'b1, osc: 1'b1};
		if (st_d != CPS_ST_RUN) begin
			gate_d.cpu   = 1'b0;
			gate_d.flash = 1'b0;
		end
		if (st_d == CPS_ST_SLEEP) begin
			case (mode)
			CPS_SM_IDLE: ;
			CPS_SM_NOISE: begin
				gate_d.io  = 1'b0;
				gate_d.pll = 1'b0;
			end
			CPS_SM_STBY: begin
				gate_d.io  = 1'b0;
				gate_d.adc = 1'b0;
				gate_d.pll = 1'b0;
			end
			default: begin
				gate_d.io  = 1'b0;
				gate_d.adc = 1'b0;
				gate_d.pll = 1'b0;
				gate_d.osc = 1'b0;
			end
			endcase
		end
	end

	// Register file and SRAM live in the core; gating never clears them.
	// Reset returns state to run so the core restarts at its vector.
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			unlock_q    <= 1'b0;
			ucnt_q      <= 3'h0;
			sel_q       <= CPS_SEL_RST_PLAIN;
			act_q       <= CPS_SEL_RST_PLAIN;
			pre_q       <= 8'h0;
			se_q        <= 1'b0;
			sm_q        <= 2'b00;
			st_q        <= CPS_ST_RUN;
			wcnt_q      <= 4'h0;
			fuse_done_q <= 1'b0;
			rdata_q     <= 32'h0;
			ack_q       <= 1'b0;
			gate_q      <= '1;
			tick_q      <= 1'b0;
			resume_q    <= 1'b0;
			adcst_q     <= 1'b0;
		end else if (CLK_EN) begin
			unlock_q    <= unlock_d;
			ucnt_q      <= ucnt_d;
			sel_q       <= sel_d;
			act_q       <= act_d;
			pre_q       <= pre_d;
			se_q        <= se_d;
			sm_q        <= sm_d;
			st_q        <= st_d;
			wcnt_q      <= wcnt_d;
			fuse_done_q <= fuse_done_d;
			rdata_q     <= rdata_d;
			ack_q       <= ack_d;
			gate_q      <= gate_d;
			tick_q      <= tick_d;
			resume_q    <= resume_d;
			adcst_q     <= adcst_d;
		end
	end

	// Checks
	a_unlock_bounded: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		ucnt_q <= CPS_UNLOCK_CYC) else $error("unlock count overrun");
	a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		ack_q && $past(AVS_ADDRESS) == CPS_OFS_DIV && $past(AVS_READ)
		|-> rdata_q[6:4] == 3'h0) else $error("reserved bits set");
	a_sleep_needs_se: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && st_q == CPS_ST_RUN && $past(st_q) == CPS_ST_RUN
		&& !se_q |=> st_q == CPS_ST_RUN) else $error("sleep without enable");
	a_idle_io_runs: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP && mode == CPS_SM_IDLE && CLK_EN
		|=> gate_q.io) else $error("idle stopped io");
	a_cpu_off_asleep: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP |-> !gate_q.cpu) else $error("cpu clock on");
	a_halt_length: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && st_q == CPS_ST_HALT && wcnt_q == CPS_WAKE_HALT
		|=> st_q == CPS_ST_HALT) else $error("halt too short");
	a_no_lock_change: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		fuse_done_q && $past(fuse_done_q) && !$past(unlock_q)
		|-> sel_q == $past(sel_q)) else $error("select changed locked");
	a_tick_once: assert property (@(posedge SYS_CLK) disable iff (!NRST)
		tick_q && act_q != 4'h0 && CLK_EN |=> !tick_q)
		else $error("tick too fast");

	// Unlock and select checks

	// Anything but the bare unlock pattern leaves a closed window shut
	a_unlock_pattern: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && wr_div && !unlock_q && AVS_WRITEDATA[7:0] != 8'h80
		|=> !unlock_q) else $error("unlock opened by bad write");
	// Bare unlock pattern written to a closed window opens it
	a_unlock_opens: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && wr_div && AVS_WRITEDATA[7:0] == 8'h80 && !unlock_q
		|=> unlock_q) else $error("unlock not opened");
	// Any select write closes the window at once
	a_select_closes: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && wr_div && !AVS_WRITEDATA[CPS_UNLOCK_BIT]
		|=> !unlock_q) else $error("unlock left open");
	// A repeated unlock never winds the timeout back
	a_repeat_keeps: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && wr_div && AVS_WRITEDATA[7:0] == 8'h80 && unlock_q
		|=> ucnt_q >= $past(ucnt_q)) else $error("timeout restarted");
	// Code written inside the window is the code stored
	a_code_taken: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && wr_div && !AVS_WRITEDATA[CPS_UNLOCK_BIT] && unlock_q
		|=> sel_q == $past(AVS_WRITEDATA[3:0])) else $error("code lost");
	// Strap value lands in the select field after reset
	a_fuse_load: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && !fuse_done_q
		|=> sel_q == ($past(DIV8_FUSE) ? CPS_SEL_RST_DIV8
			: CPS_SEL_RST_PLAIN)) else $error("fuse value not loaded");
	// Divider never runs a reserved factor
	a_factor_defined: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		act_q <= CPS_SEL_MAX) else $error("undefined factor");
	// Low enable freezes the sequencer and the divider
	a_enable_freeze: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		!CLK_EN |=> $stable(st_q) && $stable(pre_q))
		else $error("state moved while frozen");

	// Sleep gate checks

	// Idle stops only core and flash
	a_idle_gates: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP && mode == CPS_SM_IDLE
		|-> !gate_q.flash && gate_q.adc && gate_q.pll && gate_q.osc)
		else $error("idle gates wrong");
	// Noise mode keeps converter and source only
	a_noise_gates: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP && mode == CPS_SM_NOISE
		|-> gate_q.adc && gate_q.osc && !gate_q.io && !gate_q.pll)
		else $error("noise gates wrong");
	// Power-down stops every clock and the source
	a_pdown_gates: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP && mode == CPS_SM_PDOWN
		|-> gate_q == '0) else $error("power-down gates wrong");
	// Standby differs from power-down only by the running source
	a_stby_gates: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		st_q == CPS_ST_SLEEP && mode == CPS_SM_STBY
		|-> gate_q.osc && !gate_q.io && !gate_q.adc)
		else $error("standby gates wrong");

	// Wake checks

	// Deep modes ignore sources other than the listed ones
	a_deep_ignores: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && st_q == CPS_ST_SLEEP && mode == CPS_SM_PDOWN
		&& !deep_wake |=> st_q == CPS_ST_SLEEP)
		else $error("woke on wrong source");
	// Standby start-up is loaded at six cycles
	a_stby_start: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && st_q == CPS_ST_SLEEP && mode == CPS_SM_STBY && wake
		|=> wcnt_q == CPS_STBY_START) else $error("standby start-up");
	// Idle entry with converter on starts a conversion
	a_adc_start: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		CLK_EN && st_q == CPS_ST_RUN && SLEEP_INSTR && se_q
		&& ADC_ENABLED && mode == CPS_SM_IDLE
		|=> adcst_q) else $error("no conversion start");
	// Resume pulse only once the core clock runs again
	a_resume_run: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		resume_q |-> st_q == CPS_ST_RUN && gate_q.cpu)
		else $error("resume while halted");
	// Sleep never keeps the flash clock on
	a_flash_off: assert property (
		@(posedge SYS_CLK) disable iff (!NRST)
		st_q != CPS_ST_RUN |-> !gate_q.flash)
		else $error("flash clock on");
endmodule
